// ### hdl/sirq_top.sv
// Purpose: Event condition selector and autonomous wake timer.
// Assumes: Register port is the back end of the serial slave.
// Notes: Measurement pulses are one cycle, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_consts.svh"

module sirq_top
  import sirq_pkg::*;
#(
  parameter int DW = 16
)
(
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Enables and flag clears
  input wire logic int_output_enable,
  input wire logic [2:0] prox_enable,
  input wire logic [1:0] ambient_enable,
  input wire logic command_enable,
  input wire logic [5:0] flag_clear,
  // Proximity measurements
  input wire logic [2:0] prox_done,
  input wire logic [2:0][DW-1:0] prox_result,
  input wire logic [2:0][DW-1:0] prox_threshold,
  // Ambient measurements
  input wire logic visible_done,
  input wire logic [DW-1:0] visible_channel,
  input wire logic infrared_done,
  input wire logic [DW-1:0] infrared_channel,
  input wire logic [DW-1:0] ambient_lower_bound,
  input wire logic [DW-1:0] ambient_upper_bound,
  // Command response
  input wire logic response_write,
  input wire logic [7:0] response_data,
  // Flags
  output logic [2:0] prox_flag,
  output logic [1:0] ambient_flags,
  output logic command_flag,
  // Interrupt pin, open drain
  output logic int_pin_out,
  output logic int_pin_oe_n,
  // Status and wake
  output logic unlocked,
  output sirq_word_t wake_interval,
  output logic wake_start
);

  localparam logic [11:0] TICK_CYC = 12'(`SIRQ_TICK_CYC);

  generate
    if (DW < 2 || `SIRQ_TICK_CYC < 1 || `SIRQ_TICK_CYC > 4095)
    begin : g_bad_param
      $error("sirq_top: unsupported DW or tick count");
    end
  endgenerate

  logic [7:0] select_a_reg;
  logic [7:0] select_b_reg;
  logic [7:0] unlock_reg;
  logic [7:0] rate_reg;
  logic [7:0] rdata_reg;
  logic [1:0] amb_flag_reg;
  logic cmd_flag_reg;
  logic oe_n_reg;
  logic pin_reg;
  logic unlocked_reg;
  sirq_word_t interval_reg;
  sirq_word_t count_reg;
  logic [11:0] tick_reg;
  logic wake_reg;
  logic restart_reg;
  sirq_wake_e wake_state_reg;
  sirq_wake_e wake_state_next;

  // Register decode
  wire wr_a = reg_wr && reg_addr == `SIRQ_OFS_SELECT_A;
  wire wr_b = reg_wr && reg_addr == `SIRQ_OFS_SELECT_B;
  wire wr_key = reg_wr && reg_addr == `SIRQ_OFS_UNLOCK;
  wire wr_rate = reg_wr && reg_addr == `SIRQ_OFS_RATE;
  wire [7:0] rd_mux =
    (reg_addr == `SIRQ_OFS_SELECT_A) ? select_a_reg :
    (reg_addr == `SIRQ_OFS_SELECT_B) ? select_b_reg :
    (reg_addr == `SIRQ_OFS_UNLOCK) ? unlock_reg :
    (reg_addr == `SIRQ_OFS_RATE) ? rate_reg : `SIRQ_RST_BYTE;

  // Field extraction
  wire [1:0] prox1_condition =
    select_a_reg[`SIRQ_A_PROX1_HI:`SIRQ_A_PROX1_LO];
  wire [1:0] prox2_condition =
    select_a_reg[`SIRQ_A_PROX2_HI:`SIRQ_A_PROX2_LO];
  wire [2:0] ambient_condition =
    select_a_reg[`SIRQ_A_AMB_HI:`SIRQ_A_AMB_LO];
  wire [1:0] prox3_condition =
    select_b_reg[`SIRQ_B_PROX3_HI:`SIRQ_B_PROX3_LO];
  wire [1:0] command_condition =
    select_b_reg[`SIRQ_B_CMD_HI:`SIRQ_B_CMD_LO];
  wire [2:0][1:0] prox_cond =
    {prox3_condition, prox2_condition, prox1_condition};

  // Proximity channels
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_prox
      sirq_prox_flag #(
        .DW(DW)
      ) u_flag (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .enable(prox_enable[gi]),
        .condition(prox_cond[gi]),
        .done(prox_done[gi]),
        .result(prox_result[gi]),
        .threshold(prox_threshold[gi]),
        .clear(flag_clear[gi+2]),
        .flag(prox_flag[gi])
      );
    end
  endgenerate

  // Ambient window tests
  wire vis_in = visible_channel >= ambient_lower_bound
    && visible_channel <= ambient_upper_bound;
  wire ir_in = infrared_channel >= ambient_lower_bound
    && infrared_channel <= ambient_upper_bound;
  wire amb0_every = ambient_condition == `SIRQ_AMB_EVERY
    && visible_done;
  wire amb0_vis = ambient_condition[1:0] == `SIRQ_AMB_VIS_OUT
    && visible_done && !vis_in;
  wire amb0_ir = ambient_condition[1:0] == `SIRQ_AMB_IR_OUT
    && infrared_done && !ir_in;
  wire amb1_vis = ambient_condition[2:1] == `SIRQ_AMB_VIS_IN
    && visible_done && vis_in;
  wire amb1_ir = ambient_condition[2:1] == `SIRQ_AMB_IR_IN
    && infrared_done && ir_in;
  // Nothing sets without its enable bit
  wire amb0_hit = ambient_enable[0]
    && (amb0_every || amb0_vis || amb0_ir);
  wire amb1_hit = ambient_enable[1] && (amb1_vis || amb1_ir);
  wire [1:0] amb_next = {amb1_hit, amb0_hit}
    | (amb_flag_reg & ~flag_clear[1:0]);

  // Command response
  wire cmd_hit = command_enable && response_write
    && (command_condition == `SIRQ_CMD_EVERY
    || (command_condition == `SIRQ_CMD_ERROR
    && response_data[`SIRQ_RESP_ERR_BIT]));
  wire cmd_next = cmd_hit || (cmd_flag_reg && !flag_clear[5]);

  // Interrupt pin: enabled flag pulls low
  wire [5:0] all_flags = {cmd_flag_reg, prox_flag, amb_flag_reg};
  wire [5:0] all_enables = {command_enable, prox_enable, ambient_enable};
  wire int_active = int_output_enable
    && |(all_flags & all_enables);

  // Rate code expansion: high nibble exponent, four-bit mantissa
  wire [3:0] rate_exp = rate_reg[7:4];
  wire sirq_word_t rate_wide = {1'b1, rate_reg[3:0], `SIRQ_EXP_PAD};
  wire sirq_word_t expanded =
    rate_wide >> (`SIRQ_EXP_TOP - rate_exp);
  wire rate_off = rate_reg == `SIRQ_RATE_OFF;
  wire tick = tick_reg == TICK_CYC - 12'h001;
  wire expire = wake_state_reg == SIRQ_WAKE_RUN && tick
    && count_reg <= 16'h0001;
  // Rate write reloads twice: old code first, then the new one
  wire count_load = wake_state_reg != SIRQ_WAKE_RUN || wr_rate
    || restart_reg || expire;
  wire tick_hold = count_load || rate_off || tick;

  always_comb
  begin
    case (wake_state_reg)
      SIRQ_WAKE_OFF: wake_state_next = rate_off ? SIRQ_WAKE_OFF : SIRQ_WAKE_RUN;
      SIRQ_WAKE_RUN: wake_state_next = rate_off ? SIRQ_WAKE_OFF : SIRQ_WAKE_RUN;
      default: wake_state_next = SIRQ_WAKE_OFF;
    endcase
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      select_a_reg <= `SIRQ_RST_BYTE;
      select_b_reg <= `SIRQ_RST_BYTE;
      unlock_reg <= `SIRQ_RST_BYTE;
      rate_reg <= `SIRQ_RST_BYTE;
      rdata_reg <= `SIRQ_RST_BYTE;
    end
    else if (ce)
    begin
      if (wr_a)
        select_a_reg <= reg_wdata & `SIRQ_A_MASK;
      if (wr_b)
        select_b_reg <= reg_wdata & `SIRQ_B_MASK;
      if (wr_key)
        unlock_reg <= reg_wdata;
      if (wr_rate)
        rate_reg <= reg_wdata;
      if (reg_rd)
        rdata_reg <= rd_mux;
    end
  end

  // Flags and pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      amb_flag_reg <= 2'h0;
      cmd_flag_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      pin_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end
    else if (ce)
    begin
      amb_flag_reg <= amb_next;
      cmd_flag_reg <= cmd_next;
      oe_n_reg <= !int_active;
      pin_reg <= 1'b0;
      unlocked_reg <= unlock_reg == `SIRQ_UNLOCK_KEY;
    end
  end

  // Wake timer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wake_state_reg <= SIRQ_WAKE_OFF;
      tick_reg <= 12'h000;
      count_reg <= `SIRQ_RST_WORD;
      interval_reg <= `SIRQ_RST_WORD;
      wake_reg <= 1'b0;
      restart_reg <= 1'b0;
    end
    else if (ce)
    begin
      wake_state_reg <= wake_state_next;
      interval_reg <= rate_off ? `SIRQ_RST_WORD : expanded;
      wake_reg <= expire;
      restart_reg <= wr_rate;
      if (tick_hold)
        tick_reg <= 12'h000;
      else
        tick_reg <= tick_reg + 12'h001;
      if (count_load)
        count_reg <= expanded;
      else if (tick)
        count_reg <= count_reg - 16'h0001;
    end
  end

  assign reg_rdata = rdata_reg;
  assign ambient_flags = amb_flag_reg;
  assign command_flag = cmd_flag_reg;
  assign int_pin_out = pin_reg;
  assign int_pin_oe_n = oe_n_reg;
  assign unlocked = unlocked_reg;
  assign wake_interval = interval_reg;
  assign wake_start = wake_reg;

  property p_amb_off;
    @(posedge clk) disable iff (srst)
    (ambient_enable == 2'h0 && amb_flag_reg == 2'h0) |=> amb_flag_reg == 2'h0;
  endproperty
  a_amb_off: assert property (p_amb_off)
    else $error("ambient flag set while ambient disabled");

  property p_amb_every;
    @(posedge clk) disable iff (srst)
    (ce && ambient_enable[0] && ambient_condition == `SIRQ_AMB_EVERY
      && visible_done) |=> amb_flag_reg[0];
  endproperty
  a_amb_every: assert property (p_amb_every)
    else $error("visible sample did not set ambient flag 0");

  property p_amb_enter;
    @(posedge clk) disable iff (srst)
    (ce && ambient_enable[1] && ambient_condition[2:1] == `SIRQ_AMB_VIS_IN
      && visible_done && vis_in) |=> amb_flag_reg[1];
  endproperty
  a_amb_enter: assert property (p_amb_enter)
    else $error("window entry did not set ambient flag 1");

  property p_cmd_error;
    @(posedge clk) disable iff (srst)
    (ce && !cmd_flag_reg && command_condition == `SIRQ_CMD_ERROR
      && response_write && !response_data[`SIRQ_RESP_ERR_BIT])
      |=> !cmd_flag_reg;
  endproperty
  a_cmd_error: assert property (p_cmd_error)
    else $error("command flag set on non-error response");

  property p_cmd_every;
    @(posedge clk) disable iff (srst)
    (ce && command_enable && command_condition == `SIRQ_CMD_EVERY
      && response_write) |=> cmd_flag_reg;
  endproperty
  a_cmd_every: assert property (p_cmd_every)
    else $error("response write did not set command flag");

  property p_sticky;
    @(posedge clk) disable iff (srst)
    (ce && cmd_flag_reg && !flag_clear[5]) |=> cmd_flag_reg;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("command flag dropped without a clear");

  property p_pin;
    @(posedge clk) disable iff (srst)
    ce |=> int_pin_oe_n == !$past(int_active) && !int_pin_out;
  endproperty
  a_pin: assert property (p_pin)
    else $error("interrupt pin drive wrong");

  property p_rate_off;
    @(posedge clk) disable iff (srst)
    rate_off [*2] |-> !wake_start && tick_reg == 12'h000;
  endproperty
  a_rate_off: assert property (p_rate_off)
    else $error("wake timer runs with rate code zero");

  property p_expand;
    @(posedge clk) disable iff (srst)
    (rate_reg == 8'h84 |-> expanded == 16'h0140)
    and (rate_reg == 8'h94 |-> expanded == 16'h0280);
  endproperty
  a_expand: assert property (p_expand)
    else $error("rate codes 84 or 94 expand wrongly");

  property p_expand_long;
    @(posedge clk) disable iff (srst)
    (rate_reg == 8'hB9 |-> expanded == 16'h0C80)
    and (rate_reg == 8'hDF |-> expanded == 16'h3E00)
    and (rate_reg == 8'hFF |-> expanded == 16'hF800);
  endproperty
  a_expand_long: assert property (p_expand_long)
    else $error("long rate codes expand wrongly");

  property p_wake_spacing;
    @(posedge clk) disable iff (srst)
    (wake_start && !wr_rate && ce) |-> ##1 !wake_start [*3];
  endproperty
  a_wake_spacing: assert property (p_wake_spacing)
    else $error("wake pulses too close together");

endmodule : sirq_top
`default_nettype wire

// ### inc/sirq_consts.svh
// Purpose: Offsets, codes and timing counts of the event selector.
// Assumes: 100 MHz clock.
// Notes: Definitions only.
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH

// Register offsets
`define SIRQ_OFS_SELECT_A 8'h05
`define SIRQ_OFS_SELECT_B 8'h06
`define SIRQ_OFS_UNLOCK 8'h07
`define SIRQ_OFS_RATE 8'h08

// Reset values
`define SIRQ_RST_BYTE 8'h00
`define SIRQ_RST_WORD 16'h0000

// Field positions in select A
`define SIRQ_A_PROX2_HI 7
`define SIRQ_A_PROX2_LO 6
`define SIRQ_A_PROX1_HI 5
`define SIRQ_A_PROX1_LO 4
`define SIRQ_A_AMB_HI 2
`define SIRQ_A_AMB_LO 0
`define SIRQ_A_MASK 8'hF7

// Field positions in select B
`define SIRQ_B_CMD_HI 3
`define SIRQ_B_CMD_LO 2
`define SIRQ_B_PROX3_HI 1
`define SIRQ_B_PROX3_LO 0
`define SIRQ_B_MASK 8'h0F

// Proximity condition codes
`define SIRQ_PX_DONE 2'h0
`define SIRQ_PX_CROSS 2'h1
`define SIRQ_PX_ABOVE 2'h3

// Ambient condition codes
`define SIRQ_AMB_EVERY 3'h0
`define SIRQ_AMB_VIS_OUT 2'h1
`define SIRQ_AMB_IR_OUT 2'h3
`define SIRQ_AMB_VIS_IN 2'h2
`define SIRQ_AMB_IR_IN 2'h3

// Command condition codes
`define SIRQ_CMD_EVERY 2'h0
`define SIRQ_CMD_ERROR 2'h1
`define SIRQ_RESP_ERR_BIT 7

// Unlock value and stopped-rate code
`define SIRQ_UNLOCK_KEY 8'h17
`define SIRQ_RATE_OFF 8'h00

// Rate expansion: exponent high nibble, implied leading one
`define SIRQ_EXP_TOP 4'hF
`define SIRQ_EXP_PAD 11'h000

// Wake tick 31.25 us, clock period 10 ns
`define SIRQ_TICK_NS 31250
`define SIRQ_CLK_NS 10
`define SIRQ_TICK_CYC ((`SIRQ_TICK_NS + `SIRQ_CLK_NS - 1) / `SIRQ_CLK_NS)

`endif

// ### inc/sirq_pkg.sv
// Purpose: Types shared by the event selector files.
// Assumes: Nothing.
// Notes: Constants live in sirq_consts.svh.
package sirq_pkg;

  typedef enum logic [1:0]
  {
    SIRQ_WAKE_OFF = 2'b01,
    SIRQ_WAKE_RUN = 2'b10
  } sirq_wake_e;

  typedef logic [15:0] sirq_word_t;

endpackage : sirq_pkg

// ### hdl/sirq_prox_flag.sv
// Purpose: One proximity channel event flag.
// Assumes: done is a one-cycle pulse with result valid.
// Notes: Flag is sticky; set beats clear.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_consts.svh"

module sirq_prox_flag
  import sirq_pkg::*;
#(
  parameter int DW = 16
)
(
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Configuration
  input wire logic enable,
  input wire logic [1:0] condition,
  // Measurement
  input wire logic done,
  input wire logic [DW-1:0] result,
  input wire logic [DW-1:0] threshold,
  // Flag
  input wire logic clear,
  output logic flag
);

  generate
    if (DW < 2)
    begin : g_bad_width
      $error("sirq_prox_flag: DW must be at least 2");
    end
  endgenerate

  logic prev_above_reg;
  logic prev_valid_reg;
  logic flag_reg;

  wire above = result > threshold;
  // Opposite sides of the threshold on two successive samples
  wire crossed = prev_valid_reg && (above != prev_above_reg);
  wire mode_done = condition == `SIRQ_PX_DONE;
  wire mode_cross = (condition == `SIRQ_PX_CROSS) && crossed;
  wire mode_above = (condition == `SIRQ_PX_ABOVE) && above;
  // Conditions honoured only with the channel enabled
  wire hit = enable && done && (mode_done || mode_cross || mode_above);
  wire flag_next = hit || (flag_reg && !clear);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prev_above_reg <= 1'b0;
      prev_valid_reg <= 1'b0;
      flag_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (done)
      begin
        prev_above_reg <= above;
        prev_valid_reg <= 1'b1;
      end
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

  property p_above_sets;
    @(posedge clk) disable iff (srst)
    (ce && enable && done && condition == `SIRQ_PX_ABOVE
      && result > threshold) |=> flag;
  endproperty
  a_above_sets: assert property (p_above_sets)
    else $error("above-threshold sample did not set flag");

  property p_disabled_quiet;
    @(posedge clk) disable iff (srst)
    (ce && !flag && !enable) |=> !flag;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("flag set while channel disabled");

  property p_cross_sets;
    @(posedge clk) disable iff (srst)
    (ce && done && enable && condition == `SIRQ_PX_CROSS ##1
      ce && done && enable && condition == `SIRQ_PX_CROSS
      && (result > threshold) != ($past(result) > $past(threshold)))
      |=> flag;
  endproperty
  a_cross_sets: assert property (p_cross_sets)
    else $error("threshold crossing not flagged");

endmodule : sirq_prox_flag
`default_nettype wire

// ### dv/sirq_host_model.sv
// Purpose: Host side of the register port.
// Assumes: Strobes change at falling edges.
// Notes: Never issues codes the host must not send.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_consts.svh"

module sirq_host_model
(
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'hFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'hA5;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic bad;
    bad = (a == `SIRQ_OFS_RATE && d != 8'h00 && d < 8'h18);
    bad = bad || (a == `SIRQ_OFS_SELECT_B && d[3]);
    if (!bad)
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      @(negedge clk);
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    @(negedge clk);
  endtask : rd

  task automatic unlock;
    wr(`SIRQ_OFS_UNLOCK, `SIRQ_UNLOCK_KEY);
  endtask : unlock
endmodule : sirq_host_model
`default_nettype wire

// ### dv/test_sensor_irq_mode_wake_timer.sv
// Purpose: Self-checking bench for the event selector and wake timer.
// Assumes: Inputs change at falling edges.
// Notes: Wake period checked with a short rate code.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_consts.svh"

module test_sensor_irq_mode_wake_timer;
  import sirq_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, response_data = 8'h00;
  logic reg_wr, reg_rd, int_output_enable = 1'b0, command_enable = 1'b0;
  logic [2:0] prox_enable = 3'h0, prox_done = 3'h0, prox_flag;
  logic [1:0] ambient_enable = 2'h0, ambient_flags;
  logic [5:0] flag_clear = 6'h00;
  logic [2:0][15:0] prox_result = '0, prox_threshold = {3{16'h0064}};
  logic visible_done = 1'b0, infrared_done = 1'b0, response_write = 1'b0;
  logic ce = 1'b1;
  logic [15:0] visible_channel = '0, infrared_channel = '0;
  logic command_flag, int_pin_out, int_pin_oe_n, unlocked, wake_start;
  sirq_word_t wake_interval;
  logic [7:0] rc [6] = '{8'h84, 8'h94, 8'hB9, 8'hDF, 8'hFF, 8'h18};
  logic [15:0] rx [6] = '{16'h0140, 16'h0280, 16'h0C80, 16'h3E00,
    16'hF800, 16'h0003};
  int failures = 0;
  int compares = 0;
  int n;

  always #5 clk = ~clk;

  sirq_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  sirq_top #(.DW(16)) i_dut (.clk(clk), .srst(srst), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .int_output_enable(int_output_enable), .prox_enable(prox_enable),
    .ambient_enable(ambient_enable), .command_enable(command_enable),
    .flag_clear(flag_clear), .prox_done(prox_done),
    .prox_result(prox_result), .prox_threshold(prox_threshold),
    .visible_done(visible_done), .visible_channel(visible_channel),
    .infrared_done(infrared_done), .infrared_channel(infrared_channel),
    .ambient_lower_bound(16'h0064), .ambient_upper_bound(16'h00C8),
    .response_write(response_write), .response_data(response_data),
    .prox_flag(prox_flag), .ambient_flags(ambient_flags),
    .command_flag(command_flag), .int_pin_out(int_pin_out),
    .int_pin_oe_n(int_pin_oe_n), .unlocked(unlocked),
    .wake_interval(wake_interval), .wake_start(wake_start));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic clear_all;
    flag_clear = 6'h3F;
    @(negedge clk);
    flag_clear = 6'h00;
    @(negedge clk);
  endtask : clear_all

  task automatic set_prox(input int ch, input logic [1:0] c);
    if (ch == 2)
      i_host.wr(`SIRQ_OFS_SELECT_B, {6'h00, c});
    else
      i_host.wr(`SIRQ_OFS_SELECT_A, ch == 0 ? {2'h0, c, 4'h0} : {c, 6'h00});
  endtask : set_prox

  // One sample, flag, pin and stickiness, then clear
  task automatic prox_ev(input int ch, input logic [15:0] r, input logic e);
    prox_result[ch] = r;
    prox_done[ch] = 1'b1;
    @(negedge clk);
    prox_done[ch] = 1'b0;
    check(16'(prox_flag[ch]), 16'(e));
    @(negedge clk);
    check(16'(int_pin_oe_n), 16'(!(e && int_output_enable)));
    check(16'(int_pin_out), 16'h0000);
    repeat (4) @(negedge clk);
    check(16'(prox_flag[ch]), 16'(e));
    clear_all();
  endtask : prox_ev

  // Back-to-back samples, only the second one crosses
  task automatic prox_pair(input int ch);
    prox_result[ch] = 16'h0096;
    prox_done[ch] = 1'b1;
    @(negedge clk);
    check(16'(prox_flag[ch]), 16'h0000);
    prox_result[ch] = 16'h000A;
    @(negedge clk);
    prox_done[ch] = 1'b0;
    check(16'(prox_flag[ch]), 16'h0001);
    clear_all();
  endtask : prox_pair

  task automatic amb(input logic [1:0] en, input logic [2:0] c,
    input logic ir, input logic [15:0] v, input logic [1:0] e);
    ambient_enable = en;
    i_host.wr(`SIRQ_OFS_SELECT_A, {5'h00, c});
    visible_channel = v;
    infrared_channel = v;
    visible_done = !ir;
    infrared_done = ir;
    @(negedge clk);
    visible_done = 1'b0;
    infrared_done = 1'b0;
    check(16'(ambient_flags), 16'(e));
    clear_all();
  endtask : amb

  task automatic cmd(input logic en, input logic [1:0] c,
    input logic [7:0] r, input logic e);
    command_enable = en;
    i_host.wr(`SIRQ_OFS_SELECT_B, {4'h0, c, 2'h0});
    response_data = r;
    response_write = 1'b1;
    @(negedge clk);
    response_write = 1'b0;
    check(16'(command_flag), 16'(e));
    clear_all();
  endtask : cmd

  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report();
  end

  initial
  begin
    repeat (17) @(negedge clk);
    srst = 1'b0;
    for (int a = 5; a < 10; a++)
    begin
      i_host.rd(8'(a), d);
      check(16'(d), 16'h0000);
    end
    i_host.wr(`SIRQ_OFS_SELECT_A, 8'hFF);
    i_host.rd(`SIRQ_OFS_SELECT_A, d);
    check(16'(d), 16'h00F7);
    i_host.wr(`SIRQ_OFS_SELECT_B, 8'h37);
    i_host.rd(`SIRQ_OFS_SELECT_B, d);
    check(16'(d), 16'h0007);
    i_host.wr(8'h09, 8'h5A);
    i_host.rd(8'h09, d);
    check(16'(d), 16'h0000);
    i_host.unlock();
    check(16'(unlocked), 16'h0001);
    i_host.wr(`SIRQ_OFS_UNLOCK, 8'h16);
    check(16'(unlocked), 16'h0000);
    for (int ch = 0; ch < 3; ch++)
    begin
      int_output_enable = (ch != 1);
      prox_enable = 3'h0;
      set_prox(ch, `SIRQ_PX_DONE);
      prox_ev(ch, 16'h000A, 1'b0);
      prox_enable[ch] = 1'b1;
      prox_ev(ch, 16'h000A, 1'b1);
      set_prox(ch, `SIRQ_PX_ABOVE);
      prox_ev(ch, 16'h0064, 1'b0);
      prox_ev(ch, 16'h0065, 1'b1);
      set_prox(ch, `SIRQ_PX_CROSS);
      prox_ev(ch, 16'h000A, 1'b1);
      prox_ev(ch, 16'h0032, 1'b0);
      prox_ev(ch, 16'h0096, 1'b1);
      prox_pair(ch);
    end
    amb(2'b00, 3'b000, 1'b0, 16'h0096, 2'b00);
    amb(2'b00, 3'b000, 1'b1, 16'h0096, 2'b00);
    amb(2'b01, 3'b000, 1'b0, 16'h0096, 2'b01);
    amb(2'b01, 3'b001, 1'b0, 16'h0032, 2'b01);
    amb(2'b01, 3'b001, 1'b0, 16'h0096, 2'b00);
    amb(2'b01, 3'b011, 1'b1, 16'h00FA, 2'b01);
    amb(2'b01, 3'b011, 1'b0, 16'h00FA, 2'b00);
    amb(2'b10, 3'b100, 1'b0, 16'h0096, 2'b10);
    amb(2'b10, 3'b100, 1'b0, 16'h0032, 2'b00);
    amb(2'b10, 3'b110, 1'b1, 16'h00C8, 2'b10);
    amb(2'b10, 3'b110, 1'b1, 16'h00FA, 2'b00);
    cmd(1'b1, `SIRQ_CMD_EVERY, 8'h05, 1'b1);
    cmd(1'b1, `SIRQ_CMD_ERROR, 8'h05, 1'b0);
    cmd(1'b1, `SIRQ_CMD_ERROR, 8'h85, 1'b1);
    cmd(1'b0, `SIRQ_CMD_EVERY, 8'h85, 1'b0);
    // Clock enable low: no flag set, register write ignored
    command_enable = 1'b1;
    ce = 1'b0;
    response_write = 1'b1;
    @(negedge clk);
    response_write = 1'b0;
    i_host.wr(`SIRQ_OFS_SELECT_B, 8'h04);
    ce = 1'b1;
    check(16'(command_flag), 16'h0000);
    i_host.rd(`SIRQ_OFS_SELECT_B, d);
    check(16'(d), 16'h0000);
    command_enable = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      i_host.wr(`SIRQ_OFS_RATE, rc[i]);
      repeat (3) @(negedge clk);
      check(wake_interval, rx[i]);
      i_host.rd(`SIRQ_OFS_RATE, d);
      check(16'(d), 16'(rc[i]));
    end
    n = 0;
    while (wake_start !== 1'b1 && n < 12000)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    n = 1;
    while (wake_start !== 1'b1 && n < 12000)
    begin
      @(negedge clk);
      n++;
    end
    check(16'(n), 16'(3 * 3125));
    i_host.wr(`SIRQ_OFS_RATE, `SIRQ_RATE_OFF);
    repeat (3) @(negedge clk);
    check(wake_interval, 16'h0000);
    n = 0;
    repeat (10000)
    begin
      @(negedge clk);
      n += int'(wake_start === 1'b1);
    end
    check(16'(n), 16'h0000);
    final_report();
  end
endmodule : test_sensor_irq_mode_wake_timer
`default_nettype wire
